// >>> rtl/pitl_pkg.sv
package pitl_pkg;
  localparam int PITL_NUM_TERM = 8;
  localparam int PITL_SEL_W = 5;
  // Function codes of the input selectors
  localparam logic [4:0] PITL_FN_NONE = 5'h00;
  localparam logic [4:0] PITL_FN_MS1 = 5'h01;
  localparam logic [4:0] PITL_FN_MS2 = 5'h02;
  localparam logic [4:0] PITL_FN_MS3 = 5'h03;
  localparam logic [4:0] PITL_FN_RESET = 5'h04;
  localparam logic [4:0] PITL_FN_COAST = 5'h05;
  localparam logic [4:0] PITL_FN_ESTOP = 5'h07;
  localparam logic [4:0] PITL_FN_HOLD = 5'h08;
  localparam logic [4:0] PITL_FN_JOG_FORWARD_INPUT = 5'h09;
  localparam logic [4:0] PITL_FN_JOG_REVERSE_INPUT = 5'h0A;
  localparam logic [4:0] PITL_FN_UP = 5'h0B;
  localparam logic [4:0] PITL_FN_DOWN = 5'h0C;
  localparam logic [4:0] PITL_FN_FWD = 5'h0D;
  localparam logic [4:0] PITL_FN_REV = 5'h0E;
  localparam logic [4:0] PITL_FN_STOP3 = 5'h0F;
  localparam logic [4:0] PITL_FN_RAMP2 = 5'h10;
  localparam logic [4:0] PITL_FN_PFAULT = 5'h11;
  localparam logic [4:0] PITL_FN_BCD = 5'h12;
  localparam logic [4:0] PITL_FN_OPEN = 5'h13;
  localparam logic [4:0] PITL_FN_CHAN = 5'h14;
  localparam logic [4:0] PITL_FN_CNT = 5'h15;
  localparam logic [4:0] PITL_FN_CLR = 5'h16;
  localparam logic [4:0] PITL_FN_PULSE = 5'h17;
  localparam logic [4:0] PITL_FN_MAX = 5'h17;
  // Selector values after reset
  localparam logic [39:0] PITL_SEL_RST = {5'h04, 5'h0E, 5'h0D, 5'h07, 5'h03, 5'h02, 5'h01, 5'h09};
  // Fault display codes
  localparam logic [1:0] PITL_FLT_NONE = 2'h0;
  localparam logic [1:0] PITL_FLT_ESTOP = 2'h1;
  localparam logic [1:0] PITL_FLT_PERIPH = 2'h2;
  // Register offsets
  localparam logic [3:0] PITL_ADDR_SEL_BASE = 4'h0;
  localparam logic [3:0] PITL_ADDR_CNT_DIV = 4'h8;
  localparam logic [3:0] PITL_ADDR_CNT_SET = 4'h9;
  localparam logic [3:0] PITL_ADDR_STATUS = 4'hA;
  localparam logic [3:0] PITL_ADDR_CNT_VAL = 4'hB;
  localparam logic [3:0] PITL_ADDR_PULSE = 4'hC;
  localparam logic [3:0] PITL_ADDR_CTRL = 4'hD;
  localparam logic [15:0] PITL_CNT_DIV_RST = 16'h0001;
  localparam logic [15:0] PITL_CNT_SET_RST = 16'h0008;
  // Timing
  localparam int PITL_CLK_MHZ = 100;
  localparam int PITL_DEB_US = 2;
  localparam int PITL_DEB_CYC = PITL_DEB_US * PITL_CLK_MHZ;
  localparam int PITL_GATE_MS = 1;
  localparam int PITL_GATE_CYC = PITL_GATE_MS * 1000 * PITL_CLK_MHZ;
endpackage

// >>> rtl/pitl_term_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pitl_term_if;
  logic raw;
  logic level;
  logic rise;
  modport filt (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface
`default_nettype wire

// >>> rtl/pitl_debounce.sv
`timescale 1ns/1ns
`default_nettype none
module pitl_debounce
  import pitl_pkg::*;
#(
  parameter int DEB_CYC = PITL_DEB_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Terminal signals
  pitl_term_if.filt term
);
  localparam int CW = $clog2(DEB_CYC + 1);
  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic rise_q;
  logic [CW-1:0] cnt_q;

  // Two-stage synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= term.raw;
      sync2_q <= sync1_q;
    end
  end

  // Level accepted after a stable run
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (sync2_q == level_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(DEB_CYC - 1)) begin
        cnt_q <= '0;
        level_q <= sync2_q;
        rise_q <= sync2_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign term.level = level_q;
  assign term.rise = rise_q;
endmodule
`default_nettype wire

// >>> rtl/pitl_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Eight terminals, each with its own function selector
// - Codes 1-3 form multi-speed bits; code 0 does nothing
// - Code 4 activation (rising edge) clears a latched fault and resets the drive
// - Code 5 active while running commands coast stop
// - Code 7 while running trips, latches emergency code; reset refused while held
// - Code 8 active freezes the ramp at present frequency
// - Codes 9 and 10 command forward and reverse jogging
// - Codes 11 and 12 give one up or down key step per activation
// - Codes 13, 14, 15 are forward, reverse and three-wire stop
// - Code 16 active selects second ramp time set
// - Code 17 in operation trips, latches peripheral code; reset refused while held
// - Code 18 makes the terminals a binary speed word, first is LSB
// - Code 19 open gives closed loop, closed gives open loop
// - Code 20 switches compound control to single second voltage channel
// - Code 21 counts each terminal pulse
// - Code 22 active clears the counter
// - Code 23 on first selector only gives pulse-frequency setpoint, edges per gate times 1000, not clamped
// - Duplicate function assignment rejected except code 0 and binary speed
// - Counter divides pulses, flags set count, restarts from zero
module pitl_top
  import pitl_pkg::*;
#(
  parameter int NUM_TERM = PITL_NUM_TERM,
  parameter int DEB_CYC = PITL_DEB_CYC,
  parameter int GATE_CYC = PITL_GATE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Terminals, low when closed to common
  input wire logic [NUM_TERM-1:0] programmable_inputs_n,
  // Drive state
  input wire logic drive_running,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Decoded commands
  output logic [2:0] multi_speed_sel,
  output logic drive_reset,
  output logic coast_stop,
  output logic output_cut,
  output logic [1:0] fault_code,
  output logic ramp_hold,
  output logic jog_forward_input,
  output logic jog_reverse_input,
  output logic freq_up_step,
  output logic freq_down_step,
  output logic forward_run_input,
  output logic reverse_run_input,
  output logic three_wire_stop,
  output logic ramp_set_second,
  output logic [NUM_TERM-1:0] binary_speed_word,
  output logic binary_speed_en,
  output logic open_loop_sel,
  output logic single_channel_sel,
  output logic count_reached,
  output logic pulse_setpoint_en,
  output logic [15:0] pulse_freq_hz
);
  logic [NUM_TERM-1:0] act;
  logic [NUM_TERM-1:0] rise;
  logic [4:0] sel_q [NUM_TERM];
  logic [NUM_TERM-1:0] hit [32];
  logic [31:0] fn_on;
  logic [31:0] fn_rise;
  logic [15:0] div_q;
  logic [15:0] set_q;
  logic [15:0] pre_q;
  logic [15:0] cnt_q;
  logic [15:0] pcnt_q;
  logic [31:0] gate_q;
  logic [1:0] flt_q;
  logic wr_ok;

  // Per terminal filter and selector decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
      pitl_term_if tif ();
      assign tif.raw = ~programmable_inputs_n[gi];
      pitl_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .term(tif)
      );
      assign act[gi] = tif.level;
      assign rise[gi] = tif.rise;
    end
  endgenerate

  // Function matrix: which terminals hold each code
  always_comb begin
    for (int f = 0; f < 32; f++) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        hit[f][t] = (sel_q[t] == 5'(f));
      end
      fn_on[f] = |(hit[f] & act);
      fn_rise[f] = |(hit[f] & rise);
    end
  end

  // Write check: range, terminal one only for pulse, no duplicates except codes 0 and 18
  always_comb begin
    wr_ok = (reg_wdata[4:0] <= PITL_FN_MAX);
    if (reg_wdata[4:0] == PITL_FN_PULSE && reg_addr != PITL_ADDR_SEL_BASE) begin
      wr_ok = 1'b0;
    end
    for (int t = 0; t < NUM_TERM; t++) begin
      if (4'(t) != reg_addr && sel_q[t] == reg_wdata[4:0] && reg_wdata[4:0] != PITL_FN_NONE
          && reg_wdata[4:0] != PITL_FN_BCD) begin
        wr_ok = 1'b0;
      end
    end
  end

  // Selector registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        sel_q[t] <= PITL_SEL_RST[t*5 +: 5];
      end
    end else if (reg_wr && reg_addr < 4'(NUM_TERM) && wr_ok) begin
      sel_q[reg_addr[2:0]] <= reg_wdata[4:0];
    end
  end

  // Counter configuration
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_q <= PITL_CNT_DIV_RST;
      set_q <= PITL_CNT_SET_RST;
    end else if (reg_wr) begin
      if (reg_addr == PITL_ADDR_CNT_DIV && reg_wdata[15:0] != 16'h0000) begin
        div_q <= reg_wdata[15:0];
      end
      if (reg_addr == PITL_ADDR_CNT_SET && reg_wdata[15:0] != 16'h0000) begin
        set_q <= reg_wdata[15:0];
      end
    end
  end

  // Fault latch; trips win, reset only once the trip input is gone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flt_q <= PITL_FLT_NONE;
      drive_reset <= 1'b0;
    end else begin
      drive_reset <= 1'b0;
      if (fn_on[PITL_FN_ESTOP] && drive_running) begin
        flt_q <= PITL_FLT_ESTOP;
      end else if (fn_on[PITL_FN_PFAULT] && drive_running) begin
        flt_q <= PITL_FLT_PERIPH;
      end else if (fn_rise[PITL_FN_RESET] && flt_q != PITL_FLT_NONE
                   && !fn_on[PITL_FN_ESTOP] && !fn_on[PITL_FN_PFAULT]) begin
        flt_q <= PITL_FLT_NONE;
        drive_reset <= 1'b1;
      end
    end
  end

  // Level commands
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      multi_speed_sel <= 3'h0;
      coast_stop <= 1'b0;
      output_cut <= 1'b0;
      fault_code <= PITL_FLT_NONE;
      ramp_hold <= 1'b0;
      jog_forward_input <= 1'b0;
      jog_reverse_input <= 1'b0;
      forward_run_input <= 1'b0;
      reverse_run_input <= 1'b0;
      three_wire_stop <= 1'b0;
      ramp_set_second <= 1'b0;
      binary_speed_word <= '0;
      binary_speed_en <= 1'b0;
      open_loop_sel <= 1'b0;
      single_channel_sel <= 1'b0;
      pulse_setpoint_en <= 1'b0;
    end else begin
      multi_speed_sel <= {fn_on[PITL_FN_MS3], fn_on[PITL_FN_MS2], fn_on[PITL_FN_MS1]};
      coast_stop <= fn_on[PITL_FN_COAST] && drive_running;
      output_cut <= (flt_q != PITL_FLT_NONE);
      fault_code <= flt_q;
      ramp_hold <= fn_on[PITL_FN_HOLD];
      jog_forward_input <= fn_on[PITL_FN_JOG_FORWARD_INPUT];
      jog_reverse_input <= fn_on[PITL_FN_JOG_REVERSE_INPUT];
      forward_run_input <= fn_on[PITL_FN_FWD];
      reverse_run_input <= fn_on[PITL_FN_REV];
      three_wire_stop <= fn_on[PITL_FN_STOP3];
      ramp_set_second <= fn_on[PITL_FN_RAMP2];
      binary_speed_en <= |hit[PITL_FN_BCD];
      binary_speed_word <= (|hit[PITL_FN_BCD]) ? act : '0;
      open_loop_sel <= fn_on[PITL_FN_OPEN];
      single_channel_sel <= fn_on[PITL_FN_CHAN];
      pulse_setpoint_en <= (sel_q[0] == PITL_FN_PULSE);
    end
  end

  // Key step pulses, one per activation
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      freq_up_step <= 1'b0;
      freq_down_step <= 1'b0;
    end else begin
      freq_up_step <= fn_rise[PITL_FN_UP];
      freq_down_step <= fn_rise[PITL_FN_DOWN];
    end
  end

  // Divided pulse counter with set-count flag
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 16'h0000;
      cnt_q <= 16'h0000;
      count_reached <= 1'b0;
    end else begin
      count_reached <= 1'b0;
      if (fn_on[PITL_FN_CLR]) begin
        pre_q <= 16'h0000;
        cnt_q <= 16'h0000;
      end else if (fn_rise[PITL_FN_CNT]) begin
        if (pre_q + 16'h0001 >= div_q) begin
          pre_q <= 16'h0000;
          if (cnt_q + 16'h0001 >= set_q) begin
            cnt_q <= 16'h0000;
            count_reached <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end else begin
          pre_q <= pre_q + 16'h0001;
        end
      end
    end
  end

  // Pulse frequency meter over a fixed gate on the first terminal
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_q <= 32'h0000_0000;
      pcnt_q <= 16'h0000;
      pulse_freq_hz <= 16'h0000;
    end else if (sel_q[0] != PITL_FN_PULSE) begin
      gate_q <= 32'h0000_0000;
      pcnt_q <= 16'h0000;
      pulse_freq_hz <= 16'h0000;
    end else if (gate_q == 32'(GATE_CYC - 1)) begin
      gate_q <= 32'h0000_0000;
      pcnt_q <= rise[0] ? 16'h0001 : 16'h0000; // Boundary edge opens next gate
      pulse_freq_hz <= 16'((32'(pcnt_q) * 32'd1000) / 32'(PITL_GATE_MS));
    end else begin
      gate_q <= gate_q + 32'h0000_0001;
      if (rise[0] && pcnt_q != 16'hFFFF) begin
        pcnt_q <= pcnt_q + 16'h0001;
      end
    end
  end

  // Register read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr < 4'(NUM_TERM)) begin
          reg_rdata <= {27'h0, sel_q[reg_addr[2:0]]};
        end else begin
          case (reg_addr)
            PITL_ADDR_CNT_DIV: reg_rdata <= {16'h0, div_q};
            PITL_ADDR_CNT_SET: reg_rdata <= {16'h0, set_q};
            PITL_ADDR_STATUS: reg_rdata <= {22'h0, flt_q, act};
            PITL_ADDR_CNT_VAL: reg_rdata <= {16'h0, cnt_q};
            PITL_ADDR_PULSE: reg_rdata <= {16'h0, pulse_freq_hz};
            default: reg_rdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Checks
  a_fault_refuse: assert property (@(posedge clk_sys) disable iff (!rstn)
    fn_on[PITL_FN_ESTOP] |=> !drive_reset) else $error("reset during estop");
  a_estop_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    fn_on[PITL_FN_ESTOP] && drive_running |=> ##1 output_cut && fault_code == PITL_FLT_ESTOP)
    else $error("estop not latched");
  a_up_step: assert property (@(posedge clk_sys) disable iff (!rstn)
    fn_rise[PITL_FN_UP] |=> freq_up_step ##1 !freq_up_step) else $error("up step");
  a_hold_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    ramp_hold == $past(fn_on[PITL_FN_HOLD])) else $error("hold");
  a_bcd_word: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|hit[PITL_FN_BCD]) |=> binary_speed_word == $past(act)) else $error("bcd");
  a_clr_count: assert property (@(posedge clk_sys) disable iff (!rstn)
    fn_on[PITL_FN_CLR] |=> cnt_q == 16'h0000) else $error("clear");
  a_reach_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
    count_reached |-> cnt_q == 16'h0000) else $error("wrap");
  a_ramp_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
    fn_on[PITL_FN_RAMP2] |=> ramp_set_second) else $error("ramp set");
  a_pulse_first: assert property (@(posedge clk_sys) disable iff (!rstn)
    sel_q[1] != PITL_FN_PULSE) else $error("pulse on t2");
  c_reset: cover property (@(posedge clk_sys) disable iff (!rstn) drive_reset);
  c_reach: cover property (@(posedge clk_sys) disable iff (!rstn) count_reached);
  c_periph: cover property (@(posedge clk_sys) disable iff (!rstn) fault_code == PITL_FLT_PERIPH);
endmodule
`default_nettype wire

// >>> dv/pitl_contacts.sv
`timescale 1ns/1ns
`default_nettype none
// External contacts from each terminal to common
module pitl_contacts
  import pitl_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Terminal pins, pulled high while open
  output logic [PITL_NUM_TERM-1:0] pins_n
);
  initial pins_n = 8'hFF;
  // Set every contact after a clock edge
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_sys);
    pins_n <= v;
  endtask
  // Pulse train on one contact; slow against the debounce window
  task automatic pulse(input int idx, input int n, input int half);
    repeat (n) begin
      @(posedge clk_sys);
      pins_n[idx] <= 1'b0;
      repeat (half) @(posedge clk_sys);
      pins_n[idx] <= 1'b1;
      repeat (half) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// >>> dv/pitl_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pitl_top_tb
  import pitl_pkg::*;
;
  typedef struct packed {
    logic [4:0] code;
    logic run;
    logic [7:0] pins;
    logic [12:0] exp;
  } pitl_row_type;
  logic clk_sys, rstn, drive_running, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] pins_n, binary_speed_word;
  logic [2:0] multi_speed_sel;
  logic [1:0] fault_code;
  logic [15:0] pulse_freq_hz;
  logic drive_reset, coast_stop, output_cut, ramp_hold, jog_forward_input, jog_reverse_input;
  logic freq_up_step, freq_down_step, forward_run_input, reverse_run_input, three_wire_stop;
  logic ramp_set_second, binary_speed_en, open_loop_sel, single_channel_sel, count_reached;
  logic pulse_setpoint_en;
  logic [12:0] outs;
  logic [7:0] m;
  int fail_count, num_checks, n_up, n_dn, n_rch, n_rst;
  // Ordinary cases: selector of terminal 0, running, pins, decoded levels
  pitl_row_type rows [13] = '{
    '{5'h09, 1'b1, 8'hFF, 13'h0000}, '{5'h09, 1'b1, 8'hFE, 13'h0200},
    '{5'h09, 1'b1, 8'hF1, 13'h1C00}, '{5'h09, 1'b1, 8'h9F, 13'h00C0},
    '{5'h0A, 1'b1, 8'hFE, 13'h0100}, '{5'h05, 1'b1, 8'hFE, 13'h0020},
    '{5'h05, 1'b0, 8'hFE, 13'h0000}, '{5'h08, 1'b1, 8'hFE, 13'h0010},
    '{5'h0F, 1'b1, 8'hFE, 13'h0008}, '{5'h10, 1'b1, 8'hFE, 13'h0004},
    '{5'h13, 1'b1, 8'hFE, 13'h0002}, '{5'h14, 1'b1, 8'hFE, 13'h0001},
    '{5'h00, 1'b1, 8'hFE, 13'h0000}};

  assign outs = {multi_speed_sel, jog_forward_input, jog_reverse_input, forward_run_input,
    reverse_run_input, coast_stop, ramp_hold, three_wire_stop, ramp_set_second,
    open_loop_sel, single_channel_sel};

  pitl_top #(.DEB_CYC(4), .GATE_CYC(50)) u_pitl_top (
    .clk_sys(clk_sys), .rstn(rstn), .programmable_inputs_n(pins_n),
    .drive_running(drive_running), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .multi_speed_sel(multi_speed_sel), .drive_reset(drive_reset), .coast_stop(coast_stop),
    .output_cut(output_cut), .fault_code(fault_code), .ramp_hold(ramp_hold),
    .jog_forward_input(jog_forward_input), .jog_reverse_input(jog_reverse_input),
    .freq_up_step(freq_up_step), .freq_down_step(freq_down_step),
    .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input),
    .three_wire_stop(three_wire_stop), .ramp_set_second(ramp_set_second),
    .binary_speed_word(binary_speed_word), .binary_speed_en(binary_speed_en),
    .open_loop_sel(open_loop_sel), .single_channel_sel(single_channel_sel),
    .count_reached(count_reached), .pulse_setpoint_en(pulse_setpoint_en),
    .pulse_freq_hz(pulse_freq_hz));

  pitl_contacts u_pitl_contacts (.clk_sys(clk_sys), .pins_n(pins_n));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Count one-cycle event pulses
  always @(posedge clk_sys) begin
    if (freq_up_step === 1'b1) n_up++;
    if (freq_down_step === 1'b1) n_dn++;
    if (count_reached === 1'b1) n_rch++;
    if (drive_reset === 1'b1) n_rst++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Register read, data sampled in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check("reg", reg_rdata, exp);
  endtask

  // Sync plus debounce plus decode, with margin
  task automatic settle;
    repeat (16) @(posedge clk_sys);
  endtask

  task automatic press(input logic [7:0] v);
    u_pitl_contacts.set_pins(v);
    settle();
    u_pitl_contacts.set_pins(8'hFF);
    settle();
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    drive_running = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    check("idle", {outs, fault_code}, 0);
    for (int i = 0; i < 8; i++) rdchk(i[3:0], PITL_SEL_RST[5*i +: 5]);
    rdchk(4'hF, 0);
    @(negedge clk_sys);
    check("rdata idle", reg_rdata, 0);
    for (int i = 0; i < 13; i++) begin
      wr(PITL_ADDR_SEL_BASE, rows[i].code);
      drive_running <= rows[i].run;
      u_pitl_contacts.set_pins(rows[i].pins);
      settle();
      check("row", outs, rows[i].exp);
      u_pitl_contacts.set_pins(8'hFF);
      settle();
    end
    // Refused selector writes leave the old value
    wr(4'h0, 32'h0D);
    wr(4'h0, 32'h18);
    rdchk(4'h0, 0);
    wr(4'h1, 32'h17);
    rdchk(4'h1, 1);
    wr(4'h0, 32'h12);
    wr(4'h1, 32'h12);
    rdchk(4'h1, 32'h12);
    u_pitl_contacts.set_pins(8'h5A);
    drive_running <= 1'b0;
    settle();
    check("word", {binary_speed_en, binary_speed_word}, 9'h1A5);
    u_pitl_contacts.set_pins(8'hFF);
    drive_running <= 1'b1;
    wr(4'h0, 32'h11);
    settle();
    // Emergency then peripheral trip; reset refused while held
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'hFE : 8'hEF;
      u_pitl_contacts.set_pins(m);
      settle();
      check("trip", {output_cut, fault_code}, k ? 3'h6 : 3'h5);
      u_pitl_contacts.set_pins(m & 8'h7F);
      settle();
      check("held", {fault_code, n_rst[1:0]}, k ? 4'h9 : 4'h4);
      rdchk(PITL_ADDR_STATUS, k ? 32'h0000_0281 : 32'h0000_0190);
      u_pitl_contacts.set_pins(8'hFF);
      settle();
      press(8'h7F);
      check("cleared", {output_cut, fault_code}, 0);
      check("resets", n_rst, k + 1);
    end
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 32'h0C : 32'h0B);
      repeat (2) press(8'hFE);
    end
    check("up", n_up, 2);
    check("down", n_dn, 2);
    wr(4'h0, 32'h15);
    wr(PITL_ADDR_CNT_DIV, 32'h2);
    wr(PITL_ADDR_CNT_SET, 32'h3);
    u_pitl_contacts.pulse(0, 6, 20);
    settle();
    check("reached", n_rch, 1);
    rdchk(PITL_ADDR_CNT_VAL, 0);
    u_pitl_contacts.pulse(0, 2, 20);
    settle();
    rdchk(PITL_ADDR_CNT_VAL, 1);
    wr(4'h1, 32'h16);
    press(8'hFD);
    rdchk(PITL_ADDR_CNT_VAL, 0);
    wr(4'h0, 32'h17);
    fork
      u_pitl_contacts.pulse(0, 8, 12);
      begin
        repeat (150) @(posedge clk_sys);
        @(negedge clk_sys);
        check("freq", pulse_freq_hz, 16'h07D0);
        check("pulse mode", pulse_setpoint_en, 1);
      end
    join
    rdchk(PITL_ADDR_PULSE, 32'h0000_07D0);
    // Reset in mid-run restores selectors and clears outputs
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    check("rst out", {pulse_setpoint_en, pulse_freq_hz, outs}, 0);
    rdchk(PITL_ADDR_SEL_BASE, 32'h0000_0009);
    rdchk(PITL_ADDR_CNT_DIV, 32'h0000_0001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
